// [rtl/multi_pulse_pwm_unit.v]
// Purpose: eight-output multi-pulse pwm unit with apb registers
// Assumes: apb slave with no wait states, trigger pin is asynchronous
// Notes:   counter wraps to zero after holding the period value
`timescale 1ns/1ps
`include "pwm_consts.vh"

module multi_pulse_pwm_unit #(
   parameter ADDR_W = 12,
   parameter CNT_W  = 16,
   parameter PRE_W  = 8,
   parameter NCH    = 8
) (
   // clock and reset
   input  wire              clk,
   input  wire              resetn,
   // apb slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output reg  [31:0]       prdata,
   output reg               pslverr,
   // external trigger pin
   input  wire              trig_in,
   // pwm pins
   output wire [NCH-1:0]    pwm_out,
   output wire [NCH-1:0]    pwm_oe,
   // interrupt
   output wire              irq
);

   // control and configuration
   reg              trig_en_r;
   reg              trig_fall_r;
   reg              presc_en_r;
   reg              cont_r;
   reg  [CNT_W-1:0] period_r;
   reg  [PRE_W-1:0] presc_r;
   reg  [7:0]       repeat_r;
   reg  [NCH-1:0]   init_r;
   reg  [NCH-1:0]   oen_r;
   reg  [2:0]       int_stat_r;
   reg  [2:0]       int_mask_r;
   // run state
   reg              running_r;
   reg  [CNT_W-1:0] cnt_r;
   reg  [PRE_W-1:0] pre_r;
   reg  [7:0]       rep_left_r;
   reg              hit_r;
   // trigger synchroniser and edge detect
   reg              trig_s1_r;
   reg              trig_s2_r;
   reg              trig_s3_r;
   // decode
   reg  [31:0]      rd_nxt;
   reg              err_nxt;

   wire             setup;
   wire             wr;
   wire             edge_sel;
   wire [2:0]       edge_ch;
   wire             sw_start;
   wire             sw_stop;
   wire             trig_evt;
   wire             go;
   wire             tick;
   wire             at_period;
   wire             wrap;
   wire             last;
   wire             done;
   wire             restore;
   wire [NCH*(CNT_W+1)-1:0] ch_rd;
   wire [NCH-1:0]   wave;

   // apb phases
   assign pready   = 1'b1;
   assign setup    = psel & ~penable;
   assign wr       = psel & penable & pwrite;
   assign edge_sel = (paddr[ADDR_W-1:8] == `EDGE_PAGE);
   assign edge_ch  = paddr[7:5];

   // run commands
   assign sw_start = wr && paddr == `OFS_CTRL && pwdata[`CTRL_START];
   assign sw_stop  = wr && paddr == `OFS_CTRL && pwdata[`CTRL_STOP];
   assign trig_evt = trig_fall_r ? (trig_s3_r & ~trig_s2_r)
                                 : (~trig_s3_r & trig_s2_r);
   assign go       = ~running_r & (sw_start | (trig_en_r & trig_evt));

   // counter timing
   assign tick      = running_r & (~presc_en_r | pre_r == presc_r);
   assign at_period = (cnt_r == period_r);
   assign wrap      = tick & at_period;
   assign last      = ~cont_r & (rep_left_r <= 8'h01);
   assign done      = wrap & last;
   assign restore   = go | wrap | (running_r & sw_stop);

   // outputs
   assign pwm_out = wave;
   assign pwm_oe  = oen_r;
   assign irq     = |(int_stat_r & int_mask_r);

   // trigger pin passes two flops before the edge detector
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_s3_r <= 1'b0;
      end else begin
         trig_s1_r <= trig_in;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
      end
   end

   // prescaler, period counter and repeat count
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         running_r  <= 1'b0;
         cnt_r      <= {CNT_W{1'b0}};
         pre_r      <= {PRE_W{1'b0}};
         rep_left_r <= 8'h00;
         hit_r      <= 1'b0;
      end else begin
         // a new counter value appears in the next clock
         hit_r <= go | (tick & ~done);
         if (go) begin
            running_r  <= 1'b1;
            cnt_r      <= {CNT_W{1'b0}};
            pre_r      <= {PRE_W{1'b0}};
            rep_left_r <= (repeat_r == 8'h00) ? 8'h01 : repeat_r;
         end else if (running_r && sw_stop) begin
            running_r <= 1'b0;
            cnt_r     <= {CNT_W{1'b0}};
            pre_r     <= {PRE_W{1'b0}};
         end else if (running_r) begin
            if (tick) begin
               pre_r <= {PRE_W{1'b0}};
            end else begin
               pre_r <= pre_r + 1'b1;
            end
            if (wrap) begin
               cnt_r <= {CNT_W{1'b0}};
               if (done) begin
                  running_r <= 1'b0;
               end else if (!cont_r) begin
                  rep_left_r <= rep_left_r - 8'h01;
               end
            end else if (tick) begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end

   // configuration registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trig_en_r   <= 1'b0;
         trig_fall_r <= 1'b0;
         presc_en_r  <= 1'b0;
         cont_r      <= 1'b0;
         period_r    <= `RST_PERIOD;
         presc_r     <= `RST_PRESC;
         repeat_r    <= `RST_REPEAT;
         init_r      <= `RST_INIT;
         oen_r       <= `RST_OEN;
         int_mask_r  <= 3'h0;
      end else if (wr) begin
         case (paddr)
            `OFS_CTRL: begin
               trig_en_r   <= pwdata[`CTRL_TRIG_EN];
               trig_fall_r <= pwdata[`CTRL_TRIG_FALL];
               presc_en_r  <= pwdata[`CTRL_PRESC_EN];
               cont_r      <= pwdata[`CTRL_CONT];
            end
            `OFS_PERIOD:   period_r   <= pwdata[CNT_W-1:0];
            `OFS_PRESC:    presc_r    <= pwdata[PRE_W-1:0];
            `OFS_REPEAT:   repeat_r   <= pwdata[7:0];
            `OFS_INIT:     init_r     <= pwdata[NCH-1:0];
            `OFS_OEN:      oen_r      <= pwdata[NCH-1:0];
            `OFS_INT_MASK: int_mask_r <= pwdata[2:0];
            default: begin
            end
         endcase
      end
   end

   // sticky events, a set in the clearing clock wins
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_stat_r <= 3'h0;
      end else begin
         int_stat_r <= (int_stat_r
                        & ~((wr && paddr == `OFS_INT_STAT) ? pwdata[2:0]
                                                           : 3'h0))
                       | {go & ~sw_start & trig_evt, wrap, done};
      end
   end

   // read mux and unmapped detection
   always @* begin
      rd_nxt  = 32'h0000_0000;
      err_nxt = 1'b0;
      if (edge_sel) begin
         rd_nxt[CNT_W:0] = ch_rd[edge_ch*(CNT_W+1) +: (CNT_W+1)];
      end else begin
         case (paddr)
            `OFS_CTRL: begin
               rd_nxt[`CTRL_TRIG_EN]   = trig_en_r;
               rd_nxt[`CTRL_TRIG_FALL] = trig_fall_r;
               rd_nxt[`CTRL_PRESC_EN]  = presc_en_r;
               rd_nxt[`CTRL_CONT]      = cont_r;
            end
            `OFS_PERIOD:   rd_nxt[CNT_W-1:0] = period_r;
            `OFS_PRESC:    rd_nxt[PRE_W-1:0] = presc_r;
            `OFS_REPEAT:   rd_nxt[7:0]       = repeat_r;
            `OFS_INIT:     rd_nxt[NCH-1:0]   = init_r;
            `OFS_OEN:      rd_nxt[NCH-1:0]   = oen_r;
            `OFS_STATUS: begin
               rd_nxt[0]    = running_r;
               rd_nxt[15:8] = rep_left_r;
            end
            `OFS_INT_STAT: rd_nxt[2:0]       = int_stat_r;
            `OFS_INT_MASK: rd_nxt[2:0]       = int_mask_r;
            `OFS_COUNT:    rd_nxt[CNT_W-1:0] = cnt_r;
            default:       err_nxt           = 1'b1;
         endcase
      end
   end

   // read data and error captured in the setup cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr <= err_nxt;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

   // one channel per output, all fed by the same counter
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
         localparam [2:0] CH = gi;
         pwm_channel #(
            .CNT_W (CNT_W),
            .EDGES (8)
         ) u_ch (
            .clk      (clk),
            .resetn   (resetn),
            .wr_en    (wr && edge_sel && edge_ch == CH),
            .idx      (paddr[4:2]),
            .wr_data  (pwdata[CNT_W:0]),
            .rd_data  (ch_rd[gi*(CNT_W+1) +: (CNT_W+1)]),
            .cnt      (cnt_r),
            .hit_stb  (hit_r),
            .restore  (restore),
            .init_lvl (init_r[gi]),
            .wave_r   (wave[gi])
         );
      end
   endgenerate

endmodule // multi_pulse_pwm_unit

// [rtl/pwm_consts.vh]
// Purpose: shared offsets, field positions and reset values of the pwm unit
// Assumes: 12-bit apb byte addresses, 32-bit data, one word per register
// Notes:   edge words sit at 0x100 + channel*0x20 + edge*4
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH

// register byte offsets
`define OFS_CTRL      12'h000
`define OFS_PERIOD    12'h004
`define OFS_PRESC     12'h008
`define OFS_REPEAT    12'h00c
`define OFS_INIT      12'h010
`define OFS_OEN       12'h014
`define OFS_STATUS    12'h018
`define OFS_INT_STAT  12'h01c
`define OFS_INT_MASK  12'h020
`define OFS_COUNT     12'h024
`define EDGE_PAGE     4'h1

// control register fields
`define CTRL_START     0
`define CTRL_STOP      1
`define CTRL_TRIG_EN   2
`define CTRL_TRIG_FALL 3
`define CTRL_PRESC_EN  4
`define CTRL_CONT      5

// interrupt status and mask fields
`define INT_DONE 0
`define INT_WRAP 1
`define INT_TRIG 2

// edge word: value in [15:0], enable in bit 16
`define EDGE_EN 16

// reset values
`define RST_PERIOD 16'hffff
`define RST_PRESC  8'h00
`define RST_REPEAT 8'h01
`define RST_INIT   8'h00
`define RST_OEN    8'h00
`define RST_EDGE   17'h0ffff

`endif

// [rtl/pwm_channel.v]
// Purpose: one pwm output with its eight toggle points
// Assumes: hit_stb marks the first clock of a new counter value
// Notes:   restore has priority over a toggle in the same clock
`timescale 1ns/1ps
`include "pwm_consts.vh"

module pwm_channel #(
   parameter CNT_W = 16,
   parameter EDGES = 8
) (
   // clock and reset
   input  wire             clk,
   input  wire             resetn,
   // edge word access
   input  wire             wr_en,
   input  wire [2:0]       idx,
   input  wire [CNT_W:0]   wr_data,
   output wire [CNT_W:0]   rd_data,
   // timing from the shared counter
   input  wire [CNT_W-1:0] cnt,
   input  wire             hit_stb,
   input  wire             restore,
   input  wire             init_lvl,
   // waveform
   output reg              wave_r
);

   reg  [CNT_W:0] edge_r [0:EDGES-1];
   reg            match;
   integer        k;

   assign rd_data = edge_r[idx];

   // edge words, enable bit cleared so no toggle until programmed
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (k = 0; k < EDGES; k = k + 1) begin
            edge_r[k] <= `RST_EDGE;
         end
      end else if (wr_en) begin
         edge_r[idx] <= wr_data;
      end
   end

   // any enabled edge equal to the counter value
   always @* begin
      match = 1'b0;
      for (k = 0; k < EDGES; k = k + 1) begin
         if (edge_r[k][`EDGE_EN] && edge_r[k][CNT_W-1:0] == cnt) begin
            match = 1'b1;
         end
      end
   end

   // initial level at cycle start, invert on a matching value
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wave_r <= 1'b0;
      end else if (restore) begin
         wave_r <= init_lvl;
      end else if (hit_stb && match) begin
         wave_r <= ~wave_r;
      end
   end

endmodule // pwm_channel

// [tb/pwm_unit_properties.sv]
// Purpose: port assertions for the pwm unit
// Assumes: bound into every multi_pulse_pwm_unit
// Notes:   init, mask and period are shadowed from apb writes
`timescale 1ns/1ps
`include "pwm_consts.vh"

module pwm_unit_checker #(
   parameter ADDR_W = 12,
   parameter NCH    = 8
) (
   // clock and reset
   input wire              clk,
   input wire              resetn,
   // apb
   input wire              psel,
   input wire              penable,
   input wire              pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0]       pwdata,
   input wire [31:0]       prdata,
   // pins
   input wire [NCH-1:0]    pwm_out,
   input wire [NCH-1:0]    pwm_oe,
   input wire              irq
);
   // access decode
   wire           wr = psel & penable & pwrite;
   wire           rd = psel & ~penable & ~pwrite;
   wire           oe_wr = wr && paddr == `OFS_OEN;
   wire [NCH-1:0] wlow = pwdata[NCH-1:0];
   reg  [NCH-1:0] init_r;
   reg  [2:0]     mask_r;
   reg  [15:0]    per_r;

   // shadows of written settings
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         init_r <= `RST_INIT;
         mask_r <= 3'h0;
         per_r <= `RST_PERIOD;
      end else if (wr && paddr == `OFS_INIT) begin
         init_r <= wlow;
      end else if (wr && paddr == `OFS_INT_MASK) begin
         mask_r <= pwdata[2:0];
      end else if (wr && paddr == `OFS_PERIOD) begin
         per_r <= pwdata[15:0];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_oe_wr; oe_wr |=> pwm_oe == $past(wlow); endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("oe load");
   property p_oe_hold; $changed(pwm_oe) |-> $past(oe_wr); endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
   property p_oe_rd;
      rd && paddr == `OFS_OEN |=> prdata[NCH-1:0] == pwm_oe;
   endproperty
   a_oe_rd: assert property (p_oe_rd) else $error("oe read");
   property p_rst;
      $rose(resetn) |-> pwm_out == '0 && pwm_oe == '0 && !irq;
   endproperty
   a_rst: assert property (p_rst) else $error("reset pins");
   property p_mask0;
      wr && paddr == `OFS_INT_MASK && pwdata == 32'h0 |=> !irq;
   endproperty
   a_mask0: assert property (p_mask0) else $error("irq unmasked");
   property p_irq;
      rd && paddr == `OFS_INT_STAT
         |=> $past(irq) == |(prdata[2:0] & $past(mask_r));
   endproperty
   a_irq: assert property (p_irq) else $error("irq level");
   property p_cnt;
      rd && paddr == `OFS_COUNT |=> prdata <= {16'h0, per_r};
   endproperty
   a_cnt: assert property (p_cnt) else $error("count range");
   property p_stop;
      wr && paddr == `OFS_CTRL && pwdata[`CTRL_STOP] |=> pwm_out == init_r;
   endproperty
   a_stop: assert property (p_stop) else $error("stop level");
endmodule // pwm_unit_checker

bind multi_pulse_pwm_unit pwm_unit_checker #(.ADDR_W(ADDR_W), .NCH(NCH))
   u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pwm_out, .pwm_oe, .irq);

// [tb/pwm_load.sv]
// Purpose: load hanging on the pwm pins
// Assumes: every pin has a weak pull-down
// Notes:   a released pin reads low
`timescale 1ns/1ps

module pwm_load (
   // pins from the unit
   input  wire [7:0] pwm_out,
   input  wire [7:0] pwm_oe,
   // level seen by the load
   output wire [7:0] pin_lvl
);
   // pull-down wins where the pin is released
   assign pin_lvl = pwm_out & pwm_oe;
endmodule // pwm_load

// [tb/tb.sv]
// Purpose: self-checking bench for the pwm unit
// Assumes: apb slave answers through pready
// Notes:   pin levels predicted from per-value edge masks
`timescale 1ns/1ps
`include "pwm_consts.vh"

module tb;
   // design pins
   reg         clk, resetn, psel, penable, pwrite, trig_in;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   wire        pready, pslverr, irq;
   wire [31:0] prdata;
   wire [7:0]  pwm_out, pwm_oe, pin_lvl;
   // bookkeeping
   reg  [31:0] rdat;
   reg         rerr;
   integer     miscompares = 0;
   integer     total_checks = 0;

   // unit and its load
   multi_pulse_pwm_unit u_dut (.clk, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .trig_in, .pwm_out,
      .pwm_oe, .irq);
   pwm_load u_load (.pwm_out, .pwm_oe, .pin_lvl);

   // 50 mhz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      miscompares = miscompares + 1;
      test_done;
   end

   task test_done;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // compare and count
   task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %0s exp %h got %h", nm, exp, got);
      end
   endtask

   // one apb transfer, ends one ns past its completing edge
   task apb(input [11:0] a, input w, input [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task rchk(input [63:0] nm, input [11:0] a, input [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(nm, exp, rdat);
   endtask

   // reset values and a refused address
   task t_reset;
      chk("pins", 32'h0, {15'h0, irq, pwm_oe, pwm_out});
      rchk("period", `OFS_PERIOD, 32'hffff);
      rchk("repeat", `OFS_REPEAT, 32'h1);
      rchk("oen", `OFS_OEN, 32'h0);
      rchk("edge", 12'h100, 32'hffff);
      rchk("unmapped", 12'h030, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
   endtask

   // two counted cycles, eight edges on one output, irq mask and clear
   task t_run;
      integer t, e;
      reg [7:0] exp;
      reg [15:0] below;
      apb(`OFS_PERIOD, 1'b1, 32'h9);
      apb(`OFS_REPEAT, 1'b1, 32'h2);
      apb(`OFS_INIT, 1'b1, 32'h2);
      apb(`OFS_OEN, 1'b1, 32'h7);
      apb(`OFS_INT_MASK, 1'b1, 32'h1);
      apb(12'h100, 1'b1, 32'h10002);
      apb(12'h104, 1'b1, 32'h10005);
      for (e = 0; e < 8; e = e + 1) begin
         apb(12'h140 + 12'(e * 4), 1'b1, 32'h10000 + 32'(e));
      end
      apb(`OFS_CTRL, 1'b1, 32'h1);
      for (t = 0; t <= 20; t = t + 1) begin
         below = (16'h1 << (t % 10)) - 16'h1;
         exp = {5'h0, ^(16'h00ff & below), 1'b1, ^(16'h0024 & below)};
         chk("pins", {24'h0, exp}, {24'h0, pin_lvl});
         chk("irq", {31'h0, t == 20}, {31'h0, irq});
         @(posedge clk);
         #1;
      end
      chk("idle", 32'h2, {24'h0, pin_lvl});
      rchk("istat", `OFS_INT_STAT, 32'h3);
      apb(`OFS_INT_MASK, 1'b1, 32'h0);
      chk("masked", 32'h0, {31'h0, irq});
      apb(`OFS_INT_MASK, 1'b1, 32'h1);
      chk("unmask", 32'h1, {31'h0, irq});
      apb(`OFS_INT_STAT, 1'b1, 32'h1);
      chk("cleared", 32'h0, {31'h0, irq});
      rchk("istat", `OFS_INT_STAT, 32'h2);
   endtask

   // trigger start, prescaler, continuous run and stop
   task t_trig;
      integer n, k;
      apb(`OFS_PRESC, 1'b1, 32'h2);
      apb(`OFS_CTRL, 1'b1, 32'h34);
      @(posedge clk);
      trig_in <= 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
         n = 0;
         while (pin_lvl[0] !== 1'b0) begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         while (pin_lvl[0] !== 1'b1) begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         if (k > 0) chk("cycle", 32'h1e, n);
      end
      rchk("istat", `OFS_INT_STAT, 32'h6);
      apb(`OFS_CTRL, 1'b1, 32'h36);
      @(posedge clk);
      trig_in <= 1'b0;
      chk("stopped", 32'h2, {24'h0, pin_lvl});
      rchk("count", `OFS_COUNT, 32'h0);
      // falling trigger mode: a rising pin is ignored, a fall starts
      apb(`OFS_CTRL, 1'b1, 32'hc);
      trig_in <= 1'b1;
      repeat (5) @(posedge clk);
      rchk("rise_ign", `OFS_STATUS, 32'h200);
      trig_in <= 1'b0;
      repeat (5) @(posedge clk);
      rchk("fall_go", `OFS_STATUS, 32'h201);
   endtask

   // reset then scenarios
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      trig_in = 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_run;
      t_trig;
      test_done;
   end
endmodule // tb
